// ### csr_map.vh
// Address map, field positions, codes and reset values for the core special registers
`ifndef CSR_MAP_VH
`define CSR_MAP_VH
// ==========================================================
// Special register addresses
`define CSR_A_IND0 8'h00
`define CSR_A_PTR0 8'h01
`define CSR_A_IND1 8'h02
`define CSR_A_PTR1 8'h03
`define CSR_A_BANK 8'h04
`define CSR_A_ACCU 8'h05
`define CSR_A_PCLO 8'h06
`define CSR_A_TPTR 8'h07
`define CSR_A_THI 8'h08
`define CSR_A_FLAGS 8'h0a
`define CSR_A_INTC 8'h0b
`define CSR_A_EDGE 8'h2e
// First general purpose address; everything below is special space
`define CSR_SFR_TOP 8'h40
// ==========================================================
// Flag register fields
`define CSR_F_C 0
`define CSR_F_HC 1
`define CSR_F_Z 2
`define CSR_F_OVF 3
`define CSR_F_PD 4
`define CSR_F_TO 5
// Bits that a write may change (carry, aux carry, zero, overflow)
`define CSR_FLAGS_WMASK 8'h0f
// ==========================================================
// Interrupt control fields
`define CSR_I_GIE 0
`define CSR_I_ENA 1
`define CSR_I_ENB 2
`define CSR_I_PNA 4
`define CSR_I_PNB 5
// Edge select fields and codes
`define CSR_E_A_LSB 0
`define CSR_E_B_LSB 2
`define CSR_EDGE_OFF 2'h0
`define CSR_EDGE_RISE 2'h1
`define CSR_EDGE_FALL 2'h2
`define CSR_EDGE_BOTH 2'h3
// ==========================================================
// Arithmetic operation codes
`define CSR_OP_PASS 3'h0
`define CSR_OP_ADD 3'h1
`define CSR_OP_SUB 3'h2
`define CSR_OP_AND 3'h3
`define CSR_OP_OR 3'h4
`define CSR_OP_XOR 3'h5
`define CSR_OP_RLC 3'h6
`define CSR_OP_RRC 3'h7
// ==========================================================
// Reset values
`define CSR_RST_BYTE 8'h00
`define CSR_RST_BANK 8'h00
`define CSR_RD_UNUSED 8'h00
`endif

// ### csr_alu.v
// Arithmetic and logic unit with carry, aux carry, zero and overflow generation
`default_nettype none
`include "csr_map.vh"
module csr_alu (
  input wire [2:0] op,
  input wire [7:0] a,
  input wire [7:0] b,
  input wire cin,
  output reg [7:0] result,
  output reg [3:0] flags,
  output reg [3:0] upd
);
  reg [7:0] bx;
  reg [8:0] sum;
  reg [4:0] low;
  reg c7in;
  always @* begin
    // Subtraction is a + ~b + 1, so the carry out means no borrow
    bx = (op == `CSR_OP_SUB) ? ~b : b;
    sum = {1'b0, a} + {1'b0, bx} + {8'h00, (op == `CSR_OP_SUB)};
    low = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, (op == `CSR_OP_SUB)};
    c7in = sum[7] ^ a[7] ^ bx[7];
    result = b;
    flags = 4'h0;
    upd = 4'h0;
    case (op)
      `CSR_OP_ADD, `CSR_OP_SUB: begin
        result = sum[7:0];
        flags[`CSR_F_C] = sum[8];
        flags[`CSR_F_HC] = low[4];
        flags[`CSR_F_OVF] = c7in ^ sum[8];
        upd = 4'hf;
      end
      `CSR_OP_AND: begin
        result = a & b;
        upd[`CSR_F_Z] = 1'b1;
      end
      `CSR_OP_OR: begin
        result = a | b;
        upd[`CSR_F_Z] = 1'b1;
      end
      `CSR_OP_XOR: begin
        result = a ^ b;
        upd[`CSR_F_Z] = 1'b1;
      end
      `CSR_OP_RLC: begin
        result = {b[6:0], cin};
        flags[`CSR_F_C] = b[7];
        upd[`CSR_F_C] = 1'b1;
      end
      `CSR_OP_RRC: begin
        result = {cin, b[7:1]};
        flags[`CSR_F_C] = b[0];
        upd[`CSR_F_C] = 1'b1;
      end
      default: begin
        result = b;
      end
    endcase
    flags[`CSR_F_Z] = (result == 8'h00);
  end
endmodule // csr_alu
`default_nettype wire

// ### csr_core.v
// Core special registers: pointers, bank, accumulator, program counter low, table, flags
`default_nettype none
`include "csr_map.vh"
module csr_core (
  input wire core_clk,
  input wire resetn,
  input wire sys_reset_req,
  input wire reset_wdt_in_pd,
  input wire [7:0] mem_addr,
  input wire mem_rd,
  input wire mem_wr,
  input wire [7:0] mem_wdata,
  output wire [7:0] rd_data,
  output wire [7:0] ram_bank,
  output wire [7:0] ram_addr,
  output wire ram_rd,
  output wire ram_wr,
  output wire [7:0] ram_wdata,
  input wire [7:0] ram_rdata,
  input wire alu_go,
  input wire [2:0] alu_op,
  input wire [7:0] alu_operand,
  output wire [7:0] accumulator,
  input wire [7:0] pc_low_now,
  output wire pc_jump,
  output wire [7:0] pc_jump_target,
  output wire dummy_cycle,
  input wire tbl_read_go,
  output wire prog_rd,
  output wire [7:0] prog_rd_addr,
  input wire [15:0] prog_word,
  output wire tbl_low_valid,
  output wire [7:0] tbl_low_data,
  input wire halt_instr,
  input wire watchdog_clear_instr,
  input wire wdt_timeout,
  output wire power_down_flag,
  output wire watchdog_timeout_flag,
  input wire int_enter,
  input wire return_from_interrupt,
  input wire external_irq_a,
  input wire external_irq_b,
  output wire global_interrupt_enable,
  output wire [1:0] int_pending,
  output wire int_request
);
  // ==========================================================
  // Storage
  reg [7:0] pointer_bank_zero_reg;
  reg [7:0] pointer_any_bank_reg;
  reg [7:0] bank_select_reg;
  reg [7:0] accumulator_reg;
  reg [7:0] program_counter_low_reg;
  reg [7:0] table_pointer_reg;
  reg [7:0] table_high_byte_reg;
  reg [7:0] processor_flags_reg;
  reg [7:0] interrupt_control_primary_reg;
  reg [7:0] external_edge_select_reg;
  reg [7:0] sfr_rd_reg;
  reg ram_sel_reg;
  reg pc_jump_reg;
  reg dummy_reg;
  reg prog_rd_reg;
  reg tbl_low_valid_reg;
  reg [7:0] tbl_low_data_reg;
  reg [1:0] irq_a_sync_reg;
  reg [1:0] irq_b_sync_reg;
  reg irq_a_prev_reg;
  reg irq_b_prev_reg;

  // ==========================================================
  // Decode helpers
  function is_ind_port;
    input [7:0] addr;
    begin
      is_ind_port = (addr == `CSR_A_IND0) || (addr == `CSR_A_IND1);
    end
  endfunction

  function edge_hit;
    input [1:0] sel;
    input now;
    input prev;
    begin
      case (sel)
        `CSR_EDGE_RISE: edge_hit = now & ~prev;
        `CSR_EDGE_FALL: edge_hit = ~now & prev;
        `CSR_EDGE_BOTH: edge_hit = now ^ prev;
        default: edge_hit = 1'b0;
      endcase
    end
  endfunction

  // ==========================================================
  // Address resolution
  reg [7:0] eff_addr;
  reg [7:0] eff_bank;
  reg via_port;
  always @* begin
    eff_addr = mem_addr;
    eff_bank = `CSR_RST_BANK;
    via_port = 1'b0;
    if (mem_addr == `CSR_A_IND0) begin
      eff_addr = pointer_bank_zero_reg;
      eff_bank = `CSR_RST_BANK;
      via_port = 1'b1;
    end else if (mem_addr == `CSR_A_IND1) begin
      eff_addr = pointer_any_bank_reg;
      eff_bank = bank_select_reg;
      via_port = 1'b1;
    end
  end

  // Special space ignores the bank so registers stay reachable from any bank
  wire is_sfr = (eff_addr < `CSR_SFR_TOP);
  // A port pointing at a port is a dead location
  wire dead = via_port & is_ind_port(eff_addr);
  wire sfr_wr = mem_wr & is_sfr & ~dead;
  wire sfr_rd = mem_rd & is_sfr;

  assign ram_bank = eff_bank;
  assign ram_addr = eff_addr;
  assign ram_rd = mem_rd & ~is_sfr;
  assign ram_wr = mem_wr & ~is_sfr;
  assign ram_wdata = mem_wdata;
  assign rd_data = ram_sel_reg ? ram_rdata : sfr_rd_reg;

  // ==========================================================
  // Special register read mux
  reg [7:0] sfr_rd_next;
  always @* begin
    case (eff_addr)
      `CSR_A_PTR0: sfr_rd_next = pointer_bank_zero_reg;
      `CSR_A_PTR1: sfr_rd_next = pointer_any_bank_reg;
      `CSR_A_BANK: sfr_rd_next = bank_select_reg;
      `CSR_A_ACCU: sfr_rd_next = accumulator_reg;
      `CSR_A_PCLO: sfr_rd_next = pc_low_now;
      `CSR_A_TPTR: sfr_rd_next = table_pointer_reg;
      `CSR_A_THI: sfr_rd_next = table_high_byte_reg;
      `CSR_A_FLAGS: sfr_rd_next = processor_flags_reg;
      `CSR_A_INTC: sfr_rd_next = interrupt_control_primary_reg;
      `CSR_A_EDGE: sfr_rd_next = external_edge_select_reg;
      default: sfr_rd_next = `CSR_RD_UNUSED;
    endcase
    if (dead) begin
      sfr_rd_next = `CSR_RD_UNUSED;
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sfr_rd_reg <= `CSR_RST_BYTE;
      ram_sel_reg <= 1'b0;
    end else begin
      if (sfr_rd) begin
        sfr_rd_reg <= sfr_rd_next;
      end
      if (mem_rd) begin
        ram_sel_reg <= ~is_sfr;
      end
    end
  end

  // ==========================================================
  // Arithmetic unit; every result lands in the accumulator unless a write to it comes in the same cycle
  wire [7:0] alu_result;
  wire [3:0] alu_flags;
  wire [3:0] alu_upd;
  csr_alu u_alu (
    .op(alu_op),
    .a(accumulator_reg),
    .b(alu_operand),
    .cin(processor_flags_reg[`CSR_F_C]),
    .result(alu_result),
    .flags(alu_flags),
    .upd(alu_upd)
  );
  assign accumulator = accumulator_reg;

  // ==========================================================
  // Plain byte registers
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pointer_bank_zero_reg <= `CSR_RST_BYTE;
      pointer_any_bank_reg <= `CSR_RST_BYTE;
      bank_select_reg <= `CSR_RST_BANK;
      accumulator_reg <= `CSR_RST_BYTE;
      table_pointer_reg <= `CSR_RST_BYTE;
      external_edge_select_reg <= `CSR_RST_BYTE;
    end else begin
      if (sfr_wr && eff_addr == `CSR_A_PTR0) begin
        pointer_bank_zero_reg <= mem_wdata;
      end
      if (sfr_wr && eff_addr == `CSR_A_PTR1) begin
        pointer_any_bank_reg <= mem_wdata;
      end
      // A time-out reset while powered down keeps the bank
      if (sys_reset_req) begin
        if (!reset_wdt_in_pd) begin
          bank_select_reg <= `CSR_RST_BANK;
        end
      end else if (sfr_wr && eff_addr == `CSR_A_BANK) begin
        bank_select_reg <= mem_wdata;
      end
      if (sfr_wr && eff_addr == `CSR_A_ACCU) begin
        accumulator_reg <= mem_wdata;
      end else if (alu_go) begin
        accumulator_reg <= alu_result;
      end
      // Increment and decrement reach it through the ordinary write path
      if (sfr_wr && eff_addr == `CSR_A_TPTR) begin
        table_pointer_reg <= mem_wdata;
      end
      if (sfr_wr && eff_addr == `CSR_A_EDGE) begin
        external_edge_select_reg <= mem_wdata;
      end
    end
  end

  // ==========================================================
  // Program counter low and dummy cycle
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      program_counter_low_reg <= `CSR_RST_BYTE;
      pc_jump_reg <= 1'b0;
      dummy_reg <= 1'b0;
    end else begin
      pc_jump_reg <= sfr_wr && eff_addr == `CSR_A_PCLO;
      dummy_reg <= pc_jump_reg;
      if (sfr_wr && eff_addr == `CSR_A_PCLO) begin
        program_counter_low_reg <= mem_wdata;
      end
    end
  end
  // Only the low byte is supplied; the core keeps its page bits
  assign pc_jump = pc_jump_reg;
  assign pc_jump_target = program_counter_low_reg;
  assign dummy_cycle = dummy_reg;

  // ==========================================================
  // Table read: pointer out, word back one cycle later
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      table_high_byte_reg <= `CSR_RST_BYTE;
      prog_rd_reg <= 1'b0;
      tbl_low_valid_reg <= 1'b0;
      tbl_low_data_reg <= `CSR_RST_BYTE;
    end else begin
      prog_rd_reg <= tbl_read_go;
      tbl_low_valid_reg <= prog_rd_reg;
      if (prog_rd_reg) begin
        table_high_byte_reg <= prog_word[15:8];
        tbl_low_data_reg <= prog_word[7:0];
      end else if (sfr_wr && eff_addr == `CSR_A_THI) begin
        table_high_byte_reg <= mem_wdata;
      end
    end
  end
  assign prog_rd = prog_rd_reg;
  assign prog_rd_addr = table_pointer_reg;
  assign tbl_low_valid = tbl_low_valid_reg;
  assign tbl_low_data = tbl_low_data_reg;

  // ==========================================================
  // Flag register
  reg [7:0] flags_next;
  integer i;
  always @* begin
    flags_next = processor_flags_reg;
    for (i = 0; i < 4; i = i + 1) begin
      if (alu_go && alu_upd[i]) begin
        flags_next[i] = alu_flags[i];
      end
    end
    if (sfr_wr && eff_addr == `CSR_A_FLAGS) begin
      // Power-down and time-out bits are masked off here
      flags_next = (processor_flags_reg & ~`CSR_FLAGS_WMASK) |
                   (mem_wdata & `CSR_FLAGS_WMASK);
    end
    if (watchdog_clear_instr) begin
      flags_next[`CSR_F_PD] = 1'b0;
      flags_next[`CSR_F_TO] = 1'b0;
    end
    if (halt_instr) begin
      flags_next[`CSR_F_PD] = 1'b1;
      flags_next[`CSR_F_TO] = 1'b0;
    end
    // The time-out event outranks any clear in the same cycle
    if (wdt_timeout) begin
      flags_next[`CSR_F_TO] = 1'b1;
    end
    flags_next[7:6] = 2'b00;
  end

  // Interrupt entry leaves this register alone; software saves it
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      processor_flags_reg <= `CSR_RST_BYTE;
    end else begin
      processor_flags_reg <= flags_next;
    end
  end
  assign power_down_flag = processor_flags_reg[`CSR_F_PD];
  assign watchdog_timeout_flag = processor_flags_reg[`CSR_F_TO];

  // ==========================================================
  // External interrupt pins: two-stage sync, then edge detect
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq_a_sync_reg <= 2'b00;
      irq_b_sync_reg <= 2'b00;
      irq_a_prev_reg <= 1'b0;
      irq_b_prev_reg <= 1'b0;
    end else begin
      irq_a_sync_reg <= {irq_a_sync_reg[0], external_irq_a};
      irq_b_sync_reg <= {irq_b_sync_reg[0], external_irq_b};
      irq_a_prev_reg <= irq_a_sync_reg[1];
      irq_b_prev_reg <= irq_b_sync_reg[1];
    end
  end

  wire hit_a = edge_hit(external_edge_select_reg[`CSR_E_A_LSB +: 2],
                        irq_a_sync_reg[1], irq_a_prev_reg);
  wire hit_b = edge_hit(external_edge_select_reg[`CSR_E_B_LSB +: 2],
                        irq_b_sync_reg[1], irq_b_prev_reg);

  // ==========================================================
  // Interrupt control
  wire [1:0] ready_src = {interrupt_control_primary_reg[`CSR_I_PNB] &
                          interrupt_control_primary_reg[`CSR_I_ENB],
                          interrupt_control_primary_reg[`CSR_I_PNA] &
                          interrupt_control_primary_reg[`CSR_I_ENA]};
  reg [7:0] intc_next;
  always @* begin
    intc_next = interrupt_control_primary_reg;
    if (sfr_wr && eff_addr == `CSR_A_INTC) begin
      intc_next = mem_wdata;
    end
    if (int_enter) begin
      intc_next[`CSR_I_GIE] = 1'b0;
      // Source a is served first when both are ready
      if (ready_src[0]) begin
        intc_next[`CSR_I_PNA] = 1'b0;
      end else if (ready_src[1]) begin
        intc_next[`CSR_I_PNB] = 1'b0;
      end
    end
    if (return_from_interrupt) begin
      intc_next[`CSR_I_GIE] = 1'b1;
    end
    // New edges win over a clear in the same cycle
    if (hit_a) begin
      intc_next[`CSR_I_PNA] = 1'b1;
    end
    if (hit_b) begin
      intc_next[`CSR_I_PNB] = 1'b1;
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      interrupt_control_primary_reg <= `CSR_RST_BYTE;
    end else begin
      interrupt_control_primary_reg <= intc_next;
    end
  end

  assign global_interrupt_enable = interrupt_control_primary_reg[`CSR_I_GIE];
  assign int_pending = {interrupt_control_primary_reg[`CSR_I_PNB],
                        interrupt_control_primary_reg[`CSR_I_PNA]};
  assign int_request = global_interrupt_enable & (|ready_src);
endmodule // csr_core
`default_nettype wire

// ### csr_core_properties.sv
// Concurrent checks on the ports of the core special register block
`default_nettype none
module csr_core_properties (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] ram_bank,
  input wire logic pc_jump,
  input wire logic [7:0] pc_jump_target,
  input wire logic dummy_cycle,
  input wire logic tbl_read_go,
  input wire logic prog_rd,
  input wire logic [15:0] prog_word,
  input wire logic tbl_low_valid,
  input wire logic [7:0] tbl_low_data,
  input wire logic halt_instr,
  input wire logic watchdog_clear_instr,
  input wire logic wdt_timeout,
  input wire logic power_down_flag,
  input wire logic watchdog_timeout_flag,
  input wire logic int_enter,
  input wire logic return_from_interrupt,
  input wire logic global_interrupt_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  // ==========================================================
  // Program flow, table path and direct bank
  a_pc_jump_seen: assert property (
    mem_wr && mem_addr == 8'h06 |=> pc_jump && pc_jump_target == $past(mem_wdata))
    else $error("program counter low write gave no jump");
  a_dummy_after_jump: assert property (pc_jump |=> dummy_cycle)
    else $error("no dummy cycle after jump");
  a_table_pipe: assert property (
    tbl_read_go |=> prog_rd ##1 tbl_low_valid && tbl_low_data == $past(prog_word[7:0]))
    else $error("table read pipeline broken");
  a_direct_bank_zero: assert property (
    (mem_rd || mem_wr) && mem_addr >= 8'h40 |-> ram_bank == 8'h00)
    else $error("direct access left bank zero");
  // ==========================================================
  // Status flags
  a_halt_sets_pd: assert property (halt_instr |=> power_down_flag)
    else $error("halt did not set power down flag");
  a_timeout_sets_to: assert property (wdt_timeout |=> watchdog_timeout_flag)
    else $error("time-out did not set its flag");
  a_clear_drops_flags: assert property (
    watchdog_clear_instr && !halt_instr && !wdt_timeout
    |=> !power_down_flag && !watchdog_timeout_flag)
    else $error("watchdog clear left a flag set");
  a_pd_needs_cause: assert property (
    !$stable(power_down_flag) |-> $past(halt_instr || watchdog_clear_instr))
    else $error("power down flag moved without cause");
  // ==========================================================
  // Global interrupt enable
  a_enter_clears_gie: assert property (int_enter |=> !global_interrupt_enable)
    else $error("interrupt entry kept global enable");
  a_return_sets_gie: assert property (
    return_from_interrupt && !int_enter && !mem_wr |=> global_interrupt_enable)
    else $error("return did not set global enable");
endmodule // csr_core_properties

bind csr_core csr_core_properties u_props (.core_clk, .resetn, .mem_addr, .mem_rd,
  .mem_wr, .mem_wdata, .ram_bank, .pc_jump, .pc_jump_target, .dummy_cycle,
  .tbl_read_go, .prog_rd, .prog_word, .tbl_low_valid, .tbl_low_data, .halt_instr,
  .watchdog_clear_instr, .wdt_timeout, .power_down_flag, .watchdog_timeout_flag,
  .int_enter, .return_from_interrupt, .global_interrupt_enable);
`default_nettype wire

// ### csr_mem_model.sv
// Banked data memory and program memory standing behind the core registers
`default_nettype none
module csr_mem_model (
  input wire logic core_clk,
  input wire logic [7:0] ram_bank,
  input wire logic [7:0] ram_addr,
  input wire logic ram_rd,
  input wire logic ram_wr,
  input wire logic [7:0] ram_wdata,
  output var logic [7:0] ram_rdata,
  input wire logic prog_rd,
  input wire logic [7:0] prog_rd_addr,
  output logic [15:0] prog_word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:4095];
  logic [7:0] junk;
  initial begin
    junk = 8'h00;
    ram_rdata = 8'h00;
  end
  // Idle read data flips every cycle so a stale byte is never mistaken for an answer
  always @(posedge core_clk) begin
    junk <= junk + 8'h3b;
    if (ram_wr) begin
      mem[{ram_bank[3:0], ram_addr}] <= ram_wdata;
    end
    ram_rdata <= ram_rd ? mem[{ram_bank[3:0], ram_addr}] : ~ram_rdata;
  end
  assign prog_word = prog_rd ? {~prog_rd_addr, prog_rd_addr ^ 8'h5a} : {junk, ~junk};
endmodule // csr_mem_model
`default_nettype wire

// ### csr_core_bench.sv
// Self-checking bench for the core special registers
`default_nettype none
`include "csr_map.vh"
module csr_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SRST = 0, HALT = 1, CLRW = 2, WDT = 3, ENT = 4, RET = 5, ALU = 6, TBL = 7;
  logic core_clk = 1'b0, resetn = 1'b0, reset_wdt_in_pd = 1'b0, mem_rd = 1'b0, mem_wr = 1'b0;
  logic external_irq_a = 1'b0, external_irq_b = 1'b0;
  logic [7:0] ev = 8'h00, mem_addr = 8'h00, mem_wdata = 8'h00, alu_operand = 8'h00;
  logic [7:0] pc_low_now = 8'h00;
  logic [2:0] alu_op = 3'h0;
  wire sys_reset_req, halt_instr, watchdog_clear_instr, wdt_timeout, int_enter;
  wire return_from_interrupt, alu_go, tbl_read_go;
  wire [7:0] rd_data, ram_bank, ram_addr, ram_wdata, ram_rdata, accumulator, pc_jump_target;
  wire [7:0] prog_rd_addr, tbl_low_data;
  wire [15:0] prog_word;
  wire [1:0] int_pending;
  wire ram_rd, ram_wr, pc_jump, dummy_cycle, prog_rd, tbl_low_valid, power_down_flag;
  wire watchdog_timeout_flag, global_interrupt_enable, int_request;
  int n_fail = 0, check_count = 0;
  assign {tbl_read_go, alu_go, return_from_interrupt, int_enter, wdt_timeout,
    watchdog_clear_instr, halt_instr, sys_reset_req} = ev;
  csr_core DUT (.core_clk, .resetn, .sys_reset_req, .reset_wdt_in_pd, .mem_addr, .mem_rd,
    .mem_wr, .mem_wdata, .rd_data, .ram_bank, .ram_addr, .ram_rd, .ram_wr, .ram_wdata,
    .ram_rdata, .alu_go, .alu_op, .alu_operand, .accumulator, .pc_low_now, .pc_jump,
    .pc_jump_target, .dummy_cycle, .tbl_read_go, .prog_rd, .prog_rd_addr, .prog_word,
    .tbl_low_valid, .tbl_low_data, .halt_instr, .watchdog_clear_instr, .wdt_timeout,
    .power_down_flag, .watchdog_timeout_flag, .int_enter, .return_from_interrupt,
    .external_irq_a, .external_irq_b, .global_interrupt_enable, .int_pending, .int_request);
  csr_mem_model u_mem (.core_clk, .ram_bank, .ram_addr, .ram_rd, .ram_wr, .ram_wdata,
    .ram_rdata, .prog_rd, .prog_rd_addr, .prog_word);
  // ==========================================================
  // Clock and watchdog
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    #3000000;
    n_fail++;
    $display("[ERR] %0t run hung", $time);
    stop_test();
  end
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    mem_addr <= a;
    mem_wdata <= d;
    mem_wr <= 1'b1;
    @(posedge core_clk);
    mem_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string w);
    @(posedge core_clk);
    mem_addr <= a;
    mem_rd <= 1'b1;
    @(posedge core_clk);
    mem_rd <= 1'b0;
    #1 chk(rd_data, e, w);
  endtask
  task automatic pulse(input int b);
    @(posedge core_clk);
    ev[b] <= 1'b1;
    @(posedge core_clk);
    ev <= 8'h00;
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Expected {flags, result}; carry is forced clear before add and subtract
  function automatic logic [15:0] alu_ref(input logic [2:0] op, input logic [7:0] a, b, f);
    logic [8:0] s;
    logic [7:0] r, n;
    n = f;
    r = b;
    case (op)
      3'h1: begin
        s = {1'b0, a} + {1'b0, b};
        r = s[7:0];
        n[0] = s[8];
        n[1] = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0f;
        n[3] = (a[7] == b[7]) && (r[7] != a[7]);
      end
      3'h2: begin
        s = {1'b0, a} - {1'b0, b};
        r = s[7:0];
        n[0] = !s[8];
        n[1] = a[3:0] >= b[3:0];
        n[3] = (a[7] != b[7]) && (r[7] != a[7]);
      end
      3'h3: r = a & b;
      3'h4: r = a | b;
      3'h5: r = a ^ b;
      3'h6: {n[0], r} = {b, f[0]};
      3'h7: {r, n[0]} = {f[0], b};
      default: r = b;
    endcase
    if (op != 3'h0 && op < 3'h6) n[2] = (r == 8'h00);
    return {n, r};
  endfunction
  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] a, b, v, t, f;
    logic [15:0] e;
    logic [7:0] rw [5];
    logic [7:0] nu [4];
    rw = '{8'h01, 8'h03, 8'h04, 8'h05, 8'h07};
    nu = '{8'h09, 8'h0c, 8'h1f, 8'h3f};
    void'($urandom(32'ha8e88a52));
    pc_low_now <= 8'($urandom);
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    foreach (rw[i]) rd(rw[i], 8'h00, "reset value");
    rd(`CSR_A_FLAGS, 8'h00, "flags reset");
    rd(`CSR_A_PCLO, pc_low_now, "pc low read");
    foreach (rw[i]) begin
      v = 8'($urandom);
      wr(rw[i], v);
      rd(rw[i], v, "register readback");
    end
    foreach (nu[i]) begin
      wr(nu[i], 8'($urandom));
      rd(nu[i], 8'h00, "unused location");
    end
    repeat (4) begin
      a = 8'h40 + 8'($urandom % 192);
      b = 8'(1 + $urandom % 15);
      v = 8'($urandom);
      t = v ^ 8'ha5;
      wr(`CSR_A_BANK, b);
      wr(a, v);
      wr(`CSR_A_PTR1, a);
      wr(`CSR_A_IND1, t);
      rd(a, v, "direct access");
      rd(`CSR_A_IND1, t, "banked indirect");
      wr(`CSR_A_PTR0, a);
      rd(`CSR_A_IND0, v, "bank zero indirect");
    end
    wr(`CSR_A_PTR1, `CSR_A_IND1);
    rd(`CSR_A_IND1, 8'h00, "port through port");
    wr(`CSR_A_PTR0, `CSR_A_IND0);
    rd(`CSR_A_IND0, 8'h00, "port through port");
    wr(`CSR_A_BANK, 8'h07);
    wr(`CSR_A_PTR1, `CSR_A_ACCU);
    v = 8'($urandom);
    wr(`CSR_A_IND1, v);
    rd(`CSR_A_ACCU, v, "special reg from bank 7");
    reset_wdt_in_pd <= 1'b1;
    pulse(SRST);
    rd(`CSR_A_BANK, 8'h07, "bank kept");
    reset_wdt_in_pd <= 1'b0;
    pulse(SRST);
    rd(`CSR_A_BANK, 8'h00, "bank cleared");
    for (int i = 0; i < 32; i++) begin
      a = (i < 8) ? 8'hff : 8'($urandom);
      b = (i < 8) ? 8'h01 : 8'($urandom);
      f = 8'($urandom % 16);
      if (i[2:0] == 3'h1 || i[2:0] == 3'h2) f[0] = 1'b0;
      wr(`CSR_A_FLAGS, f);
      wr(`CSR_A_ACCU, a);
      alu_op <= i[2:0];
      alu_operand <= b;
      pulse(ALU);
      e = alu_ref(i[2:0], a, b, f);
      chk(accumulator, e[7:0], "accumulator port");
      rd(`CSR_A_ACCU, e[7:0], "alu result");
      rd(`CSR_A_FLAGS, e[15:8], "alu flags");
    end
    wr(`CSR_A_FLAGS, 8'hff);
    rd(`CSR_A_FLAGS, 8'h0f, "flag write mask");
    v = 8'($urandom);
    wr(`CSR_A_PCLO, v);
    #1 chk(8'(pc_jump), 8'h01, "jump pulse");
    chk(pc_jump_target, v, "jump target");
    @(posedge core_clk);
    #1 chk(8'(dummy_cycle), 8'h01, "dummy cycle");
    repeat (2) begin
      t = 8'($urandom);
      wr(`CSR_A_TPTR, t);
      pulse(TBL);
      @(posedge core_clk);
      #1 chk(tbl_low_data, t ^ 8'h5a, "table low byte");
      chk(8'(tbl_low_valid), 8'h01, "table valid");
      rd(`CSR_A_THI, ~t, "table high byte");
    end
    pulse(HALT);
    chk(8'({power_down_flag, watchdog_timeout_flag}), 8'h02, "halt");
    pulse(WDT);
    chk(8'({power_down_flag, watchdog_timeout_flag}), 8'h03, "time-out");
    wr(`CSR_A_FLAGS, 8'h00);
    rd(`CSR_A_FLAGS, 8'h30, "flag write keeps status");
    pulse(HALT);
    chk(8'({power_down_flag, watchdog_timeout_flag}), 8'h02, "halt clears");
    pulse(CLRW);
    chk(8'({power_down_flag, watchdog_timeout_flag}), 8'h00, "clear");
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 4; c++) begin
        f = 8'(p == 0) | (8'h02 << p);
        wr(`CSR_A_INTC, 8'h00);
        wr(`CSR_A_EDGE, 8'(c << (2 * p)));
        wr(`CSR_A_INTC, f);
        {external_irq_b, external_irq_a} <= 2'(p + 1);
        repeat (6) @(posedge core_clk);
        #1 chk(8'(int_pending[p]), 8'(c % 2), "rising edge");
        chk(8'(int_request), 8'(c % 2 == 1 && p == 0), "request gate");
        wr(`CSR_A_INTC, f);
        {external_irq_b, external_irq_a} <= 2'b00;
        repeat (6) @(posedge core_clk);
        #1 chk(8'(int_pending[p]), 8'(c / 2), "falling edge");
      end
    end
    pulse(RET);
    chk(8'({global_interrupt_enable, int_request}), 8'h03, "return");
    pulse(ENT);
    chk(8'({global_interrupt_enable, int_request}), 8'h00, "entry");
    rd(`CSR_A_FLAGS, 8'h00, "flags untouched by entry");
    stop_test();
  end
endmodule // csr_core_bench
`default_nettype wire
